// ---- hw/nbl_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module nbl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
      nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready  = cnt_q != (AW+1)'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      wr_d  = push ? nxt(wr_q) : wr_q;
      rd_d  = pop ? nxt(rd_q) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ---- hw/nbl_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "nbl_params.svh"

// Notes on behaviour
// - strobe pulsed low, byte valid at rise
// - hold write protect low across power
// - five address cycles, column then row
// - column cycles carry A7..A0, A12..A8
// - row cycles carry A20..A13, A28..A21
// - fifth cycle carries die and A29
// - spare column forces bits 11..8 zero
// - read is 00h, address, 30h, busy
module nbl_host
   import nbl_pkg::*;
#(
   parameter int FIFO_DEPTH = `NBL_FIFO_DEPTH
) (
   input  wire logic                       clk,
   input  wire logic                       nrst,
   // User side
   input  wire logic                       rd_start,
   input  wire logic [`NBL_COL_BITS-1:0]   rd_col,
   input  wire logic [`NBL_ROW_BITS-1:0]   rd_row,
   input  wire logic [12:0]                rd_len,
   output logic                            rd_ready,
   output logic      [7:0]                 rd_data,
   output logic                            rd_valid,
   input  wire logic                       rd_take,
   input  wire logic                       raw_start,
   input  wire nbl_pkg::nbl_op_t           raw_op,
   input  wire logic [7:0]                 raw_byte,
   input  wire logic                       wp_allow,
   output logic                            flash_busy,
   // Flash pins
   output logic      [7:0]                 io_out,
   output logic                            io_oe,
   input  wire logic [7:0]                 io_in,
   output logic                            cmd_latch,
   output logic                            addr_latch,
   output logic                            write_strobe_n,
   output logic                            read_strobe_n,
   output logic                            chip_select_n,
   output logic                            write_protect_n,
   input  wire logic                       ready_busy_n
);
   nbl_state_t           st_q, st_d;
   logic [3:0]           tmr_q, tmr_d;
   logic [2:0]           acyc_q, acyc_d;
   logic [12:0]          left_q, left_d;
   logic [`NBL_COL_BITS-1:0] col_q, col_d;
   logic [`NBL_ROW_BITS-1:0] row_q, row_d;
   logic [7:0]           byte_q, byte_d;
   logic                 we_n_q, we_n_d, re_n_q, re_n_d;
   logic                 cle_q, cle_d, ale_q, ale_d, ce_n_q, ce_n_d;
   logic                 rb_s1_q, rb_s2_q, fifo_ready, fifo_push;
   logic [7:0]           io_s1_q, io_s2_q;

   // ----------------------------------------
   // Address cycle layout
   // ----------------------------------------
   function automatic logic [7:0] addr_byte(input logic [2:0] n,
                                            input logic [`NBL_COL_BITS-1:0] c,
                                            input logic [`NBL_ROW_BITS-1:0] r);
      logic [`NBL_COL_BITS-1:0] cc;
      cc = c;
      if (cc[12]) begin
         cc[11:8] = 4'h0;
      end
      case (n)
         3'h0:    addr_byte = cc[7:0];
         3'h1:    addr_byte = {3'h0, cc[12:8]};
         3'h2:    addr_byte = r[7:0];
         3'h3:    addr_byte = r[15:8];
         3'h4:    addr_byte = {6'h00, r[17:16]};
         default: addr_byte = 8'h00;
      endcase
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
         io_s1_q <= 8'h00;
         io_s2_q <= 8'h00;
      end else begin
         rb_s1_q <= ready_busy_n;
         rb_s2_q <= rb_s1_q;
         io_s1_q <= io_in;
         io_s2_q <= io_s1_q;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      st_d      = st_q;
      tmr_d     = tmr_q;
      acyc_d    = acyc_q;
      left_d    = left_q;
      col_d     = col_q;
      row_d     = row_q;
      byte_d    = byte_q;
      we_n_d    = we_n_q;
      re_n_d    = re_n_q;
      cle_d     = cle_q;
      ale_d     = ale_q;
      ce_n_d    = ce_n_q;
      fifo_push = 1'b0;
      if (tmr_q != 4'h0) begin
         tmr_d = tmr_q - 4'h1;
      end
      case (st_q)
         NBL_IDLE: begin
            ce_n_d = 1'b1;
            if (rd_start) begin
               col_d  = rd_col;
               row_d  = rd_row;
               left_d = (rd_len > `NBL_PAGE_BYTES) ? `NBL_PAGE_BYTES : rd_len;
               byte_d = `NBL_CMD_READ;
               ce_n_d = 1'b0;
               cle_d  = 1'b1;
               st_d   = NBL_CMD;
            end else if (raw_start) begin
               byte_d = raw_byte;
               ce_n_d = 1'b0;
               cle_d  = raw_op == NBL_OP_CMD;
               ale_d  = raw_op == NBL_OP_ADDR;
               st_d   = NBL_DATAW;
            end
         end
         NBL_CMD, NBL_ADDR, NBL_CONF, NBL_DATAW: begin
            if (we_n_q && tmr_q == 4'h0) begin
               we_n_d = 1'b0;
               tmr_d  = 4'(`NBL_STROBE_LOW_CYC - 1);
            end else if (!we_n_q && tmr_q == 4'h0) begin
               we_n_d = 1'b1;
               tmr_d  = 4'(`NBL_STROBE_HIGH_CYC);
               st_d   = NBL_CMDW;
            end
         end
         NBL_CMDW: begin
            if (tmr_q == 4'h0) begin
               cle_d = 1'b0;
               ale_d = 1'b0;
               if (byte_q == `NBL_CMD_READ && acyc_q == 3'h0 && left_q != 13'h0 && cle_q) begin
                  ale_d  = 1'b1;
                  byte_d = addr_byte(3'h0, col_q, row_q);
                  acyc_d = 3'h1;
                  st_d   = NBL_ADDR;
               end else if (ale_q && left_q != 13'h0 && acyc_q < `NBL_ADDR_CYCLES) begin
                  ale_d  = 1'b1;
                  byte_d = addr_byte(acyc_q, col_q, row_q);
                  acyc_d = acyc_q + 3'h1;
                  st_d   = NBL_ADDR;
               end else if (ale_q && left_q != 13'h0) begin
                  cle_d  = 1'b1;
                  byte_d = `NBL_CMD_READ_CONF;
                  st_d   = NBL_CONF;
               end else if (cle_q && left_q != 13'h0 && byte_q == `NBL_CMD_READ_CONF) begin
                  tmr_d  = 4'h3;
                  st_d   = NBL_BUSY;
               end else begin
                  st_d   = NBL_IDLE;
               end
            end
         end
         NBL_BUSY: begin
            // Chip select held; a deselect here would not stop the device
            if (tmr_q == 4'h0 && rb_s2_q) begin
               st_d = NBL_READ;
            end
         end
         NBL_READ: begin
            if (left_q == 13'h0) begin
               acyc_d = 3'h0;
               st_d   = NBL_IDLE;
            end else if (re_n_q && tmr_q == 4'h0 && fifo_ready) begin
               re_n_d = 1'b0;
               tmr_d  = 4'(`NBL_STROBE_LOW_CYC + 1);
            end else if (!re_n_q && tmr_q == 4'h0) begin
               re_n_d    = 1'b1;
               fifo_push = 1'b1;
               left_d    = left_q - 13'h1;
               tmr_d     = 4'(`NBL_STROBE_HIGH_CYC);
            end
         end
         default: st_d = NBL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_q   <= NBL_IDLE;
         tmr_q  <= 4'h0;
         acyc_q <= 3'h0;
         left_q <= 13'h0;
         col_q  <= '0;
         row_q  <= '0;
         byte_q <= 8'h00;
         we_n_q <= 1'b1;
         re_n_q <= 1'b1;
         cle_q  <= 1'b0;
         ale_q  <= 1'b0;
         ce_n_q <= 1'b1;
      end else begin
         st_q   <= st_d;
         tmr_q  <= tmr_d;
         acyc_q <= acyc_d;
         left_q <= left_d;
         col_q  <= col_d;
         row_q  <= row_d;
         byte_q <= byte_d;
         we_n_q <= we_n_d;
         re_n_q <= re_n_d;
         cle_q  <= cle_d;
         ale_q  <= ale_d;
         ce_n_q <= ce_n_d;
      end
   end

   // ----------------------------------------
   // Read data buffer
   // ----------------------------------------
   nbl_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_data   (io_s2_q),
      .in_valid  (fifo_push),
      .in_ready  (fifo_ready),
      .out_data  (rd_data),
      .out_valid (rd_valid),
      .out_ready (rd_take)
   );

   assign rd_ready        = st_q == NBL_IDLE;
   assign flash_busy      = !rb_s2_q;
   assign io_out          = byte_q;
   assign io_oe           = st_q != NBL_READ && st_q != NBL_BUSY && !ce_n_q;
   assign cmd_latch       = cle_q;
   assign addr_latch      = ale_q;
   assign write_strobe_n  = we_n_q;
   assign read_strobe_n   = re_n_q;
   assign chip_select_n   = ce_n_q;
   assign write_protect_n = wp_allow && nrst;
endmodule
`default_nettype wire

// ---- shared/nbl_params.svh ----
`ifndef NBL_PARAMS_SVH
`define NBL_PARAMS_SVH

// ----------------------------------------
// Bus timing in clock cycles at 10 MHz
// ----------------------------------------
`define NBL_CLK_PERIOD_NS   100
`define NBL_STROBE_LOW_NS   100
`define NBL_STROBE_HIGH_NS  100
`define NBL_STROBE_LOW_CYC  ((`NBL_STROBE_LOW_NS + `NBL_CLK_PERIOD_NS - 1) / `NBL_CLK_PERIOD_NS)
`define NBL_STROBE_HIGH_CYC ((`NBL_STROBE_HIGH_NS + `NBL_CLK_PERIOD_NS - 1) / `NBL_CLK_PERIOD_NS)

// ----------------------------------------
// Commands and address layout
// ----------------------------------------
`define NBL_CMD_READ        8'h00
`define NBL_CMD_READ_CONF   8'h30
`define NBL_ADDR_CYCLES     3'h5
`define NBL_COL_BITS        13
`define NBL_ROW_BITS        18
`define NBL_MAIN_BYTES      13'h1000
`define NBL_SPARE_BYTES     13'h0100
`define NBL_PAGE_BYTES      13'h1100
`define NBL_PAGE_BITS       6
`define NBL_PLANE_ROW_POS   6
`define NBL_DIE_ROW_POS     17
`define NBL_FIFO_DEPTH      8

`endif

// ---- shared/nbl_pkg.sv ----
package nbl_pkg;
   typedef enum logic [3:0] {
      NBL_IDLE   = 4'b0000,
      NBL_CMD    = 4'b0001,
      NBL_ADDR   = 4'b0010,
      NBL_CONF   = 4'b0011,
      NBL_BUSY   = 4'b0100,
      NBL_READ   = 4'b0101,
      NBL_CMDW   = 4'b0110,
      NBL_ADDRW  = 4'b0111,
      NBL_DATAW  = 4'b1000
   } nbl_state_t;

   typedef enum logic [1:0] {
      NBL_OP_READ  = 2'b00,
      NBL_OP_CMD   = 2'b01,
      NBL_OP_ADDR  = 2'b10,
      NBL_OP_DATA  = 2'b11
   } nbl_op_t;
endpackage

// ---- sim/nbl_flash_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module nbl_flash_model #(
   parameter int HOLD_NS = 100
) (
   input  wire logic [7:0]  bus,
   output logic      [7:0]  drive,
   input  wire logic        cle,
   input  wire logic        ale,
   input  wire logic        we_n,
   input  wire logic        re_n,
   input  wire logic        ce_n,
   input  wire logic        wp_n,
   output logic             rb_pull_low,
   input  wire logic [31:0] busy_ns
);
   logic [12:0] col_q;
   logic [17:0] row_q;
   logic [2:0]  acyc_q;
   logic        standby;
   initial begin
      drive       = 8'hA5;
      rb_pull_low = 1'b0;
      acyc_q      = 3'h0;
   end
   assign standby = ce_n && !rb_pull_low;
   // ----------------
   // Bytes taken at the write strobe rise
   // ----------------
   always @(posedge we_n) begin
      if (!ce_n && cle) begin
         if (bus == 8'h00) acyc_q = 3'h0;
         if (bus == 8'h60) acyc_q = 3'h2;
         if (bus == 8'h30 || (bus == 8'hD0 && wp_n)) begin
            rb_pull_low = 1'b1;
            rb_pull_low <= #(busy_ns) 1'b0;
         end
      end else if (!ce_n && ale) begin
         case (acyc_q)
            3'h0: col_q[7:0] = bus;
            3'h1: col_q[12:8] = bus[4:0];
            3'h2: row_q[7:0] = bus;
            3'h3: row_q[15:8] = bus;
            default: row_q[17:16] = bus[1:0];
         endcase
         acyc_q = acyc_q + 3'h1;
      end
   end
   // Page buffer content, plane and die folded in
   function automatic logic [7:0] page_byte(input logic [12:0] c, input logic [17:0] r);
      return c[7:0] ^ {r[17], r[6], r[5:0]} ^ {3'h0, c[12:8]};
   endfunction
   always @(negedge re_n) begin
      if (!ce_n && !rb_pull_low) begin
         drive <= #20 page_byte(col_q, row_q);
         col_q = (col_q == 13'h10FF) ? 13'h0000 : col_q + 13'h0001;
      end
   end
   // Released bus shows garbage after hold
   always @(posedge re_n) drive <= #(HOLD_NS) ~drive;
endmodule
`default_nettype wire

// ---- sim/nbl_host_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module nbl_host_checker #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       wp_allow,
   input  wire logic       flash_busy,
   input  wire logic [7:0] io_out,
   input  wire logic       io_oe,
   input  wire logic       cmd_latch,
   input  wire logic       addr_latch,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       chip_select_n,
   input  wire logic       write_protect_n,
   input  wire logic       ready_busy_n
);
   // ----------------
   // Address bytes since last command
   // ----------------
   logic       we_q, we_d;
   logic [2:0] acnt_q, acnt_d;
   always_comb begin
      we_d   = nrst ? write_strobe_n : 1'b1;
      acnt_d = nrst ? acnt_q : 3'h0;
      if (nrst && we_q && !write_strobe_n && cmd_latch) begin
         acnt_d = 3'h0;
      end else if (nrst && !we_q && write_strobe_n && addr_latch) begin
         acnt_d = acnt_q + 3'h1;
      end
   end
   always_ff @(posedge clk) begin
      we_q   <= we_d;
      acnt_q <= acnt_d;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_latch_exclusive: assert property (!(cmd_latch && addr_latch))
      else $error("both latch selects high");
   a_latch_steady: assert property (!write_strobe_n || $rose(write_strobe_n)
      |-> $stable(cmd_latch) && $stable(addr_latch) && $stable(io_out))
      else $error("bus moved under write strobe");
   a_strobe_driven: assert property (!write_strobe_n |-> io_oe && !chip_select_n && read_strobe_n)
      else $error("write strobe without drive or select");
   a_read_selected: assert property (!read_strobe_n |-> !chip_select_n && !io_oe)
      else $error("read strobe without select");
   a_addr_count: assert property ($fell(write_strobe_n) && addr_latch |-> acnt_q < 3'h5)
      else $error("more than five address bytes");
   a_col_high_low: assert property ($fell(write_strobe_n) && addr_latch && acnt_q == 3'h1
      |-> io_out[7:5] == 3'h0 && (!io_out[4] || io_out[3:0] == 4'h0))
      else $error("bad second column byte");
   a_row_top_low: assert property ($fell(write_strobe_n) && addr_latch && acnt_q == 3'h4
      |-> io_out[7:2] == 6'h00)
      else $error("bad fifth address byte");
   a_confirm_after_addr: assert property ($fell(write_strobe_n) && cmd_latch && io_out == 8'h30
      |-> acnt_q == 3'h5)
      else $error("read confirm without five address bytes");
   a_read_when_ready: assert property ($fell(read_strobe_n) |-> ready_busy_n && $past(ready_busy_n, 2))
      else $error("read strobe while busy");
   a_busy_seen: assert property (!ready_busy_n [*3] |-> flash_busy)
      else $error("busy not reported");
   a_wp_follows: assert property (write_protect_n == wp_allow)
      else $error("write protect not following request");
endmodule
bind nbl_host nbl_host_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .clk(clk), .nrst(nrst), .wp_allow(wp_allow), .flash_busy(flash_busy), .io_out(io_out),
   .io_oe(io_oe), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
   .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
   .chip_select_n(chip_select_n), .write_protect_n(write_protect_n),
   .ready_busy_n(ready_busy_n));
`default_nettype wire

// ---- sim/test_nbl_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "nbl_params.svh"
module test_nbl_host;
   import nbl_pkg::*;
   logic        clk, nrst, rd_start, rd_ready, rd_valid, rd_take, raw_start, wp_allow;
   logic        flash_busy, io_oe, cmd_latch, addr_latch, write_strobe_n, read_strobe_n;
   logic        chip_select_n, write_protect_n, ready_busy_n, rb_pull_low;
   logic [12:0] rd_col, rd_len;
   logic [17:0] rd_row;
   logic [7:0]  rd_data, raw_byte, io_out, io_in, mdl_drive, ers [5];
   logic [31:0] busy_ns;
   nbl_op_t     raw_op;
   int          miscompares, tests_run;
   assign io_in        = io_oe ? io_out : mdl_drive;
   assign ready_busy_n = !rb_pull_low;
   nbl_host #(.FIFO_DEPTH(`NBL_FIFO_DEPTH)) u_dut (
      .clk(clk), .nrst(nrst), .rd_start(rd_start), .rd_col(rd_col), .rd_row(rd_row),
      .rd_len(rd_len), .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_take(rd_take), .raw_start(raw_start), .raw_op(raw_op), .raw_byte(raw_byte),
      .wp_allow(wp_allow), .flash_busy(flash_busy), .io_out(io_out), .io_oe(io_oe),
      .io_in(io_in), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
      .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .chip_select_n(chip_select_n), .write_protect_n(write_protect_n),
      .ready_busy_n(ready_busy_n));
   nbl_flash_model u_mdl (
      .bus(io_in), .drive(mdl_drive), .cle(cmd_latch), .ale(addr_latch), .we_n(write_strobe_n),
      .re_n(read_strobe_n), .ce_n(chip_select_n), .wp_n(write_protect_n),
      .rb_pull_low(rb_pull_low), .busy_ns(busy_ns));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [7:0] exp_byte(input logic [12:0] c, input logic [17:0] r);
      return c[7:0] ^ {r[17], r[6], r[5:0]} ^ {3'h0, c[12:8]};
   endfunction
   task automatic print_verdict();
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic wait_ready();
      int k;
      k = 0;
      while (rd_ready !== 1'b1 && k < 3000) begin
         step(1);
         k++;
      end
      check("rd_ready", 1, rd_ready);
   endtask
   task automatic page_read(input logic [12:0] c, input logic [17:0] r, input int n,
                            input int stall, input logic [31:0] bns);
      int k;
      logic [12:0] ec;
      ec = c[12] ? {1'b1, 4'h0, c[7:0]} : c;
      wait_ready();
      busy_ns  = bns;
      rd_col   = c;
      rd_row   = r;
      rd_len   = 13'(n);
      rd_start = 1'b1;
      step(1);
      rd_start = 1'b0;
      step(stall);
      if (stall > 100) check("read_strobe_n", 1, read_strobe_n);
      for (int i = 0; i < n; i++) begin
         k = 0;
         while (rd_valid !== 1'b1 && k < 3000) begin
            step(1);
            k++;
         end
         check("rd_valid", 1, rd_valid);
         check("rd_data", exp_byte(ec + 13'(i), r), rd_data);
         rd_take = 1'b1;
         step(1);
         rd_take = 1'b0;
      end
   endtask
   task automatic raw(input nbl_op_t op, input logic [7:0] b);
      wait_ready();
      raw_op    = op;
      raw_byte  = b;
      raw_start = 1'b1;
      step(1);
      raw_start = 1'b0;
      step(1);
   endtask
   initial begin
      nrst        = 1'b0;
      rd_start    = 1'b0;
      rd_take     = 1'b0;
      raw_start   = 1'b0;
      raw_op      = NBL_OP_CMD;
      raw_byte    = 8'h00;
      rd_col      = 13'h0000;
      rd_row      = 18'h00000;
      rd_len      = 13'h0000;
      wp_allow    = 1'b1;
      busy_ns     = 32'd500;
      miscompares = 0;
      tests_run   = 0;
      ers         = '{8'h60, 8'h40, 8'h00, 8'h00, 8'hD0};
      void'($urandom(32'h59DCA564));
      repeat (6) @(posedge clk);
      #10;
      check("write_protect_n", 0, write_protect_n);
      check("chip_select_n", 1, chip_select_n);
      nrst = 1'b1;
      step(1);
      page_read(13'h0FFC, 18'h00000, 8, 0, 32'd500);
      page_read(13'h1A00, 18'h20041, 12, 150, 32'd3000);
      for (int t = 0; t < 5; t++) begin
         page_read(13'($urandom % 4096), 18'($urandom), 1 + $urandom % 12, $urandom % 40,
                   32'(300 + $urandom % 4000));
      end
      busy_ns = 32'd2000;
      for (int w = 0; w < 2; w++) begin
         wp_allow = w[0];
         raw(NBL_OP_DATA, 8'($urandom));
         for (int j = 0; j < 5; j++) begin
            raw((j == 0 || j == 4) ? NBL_OP_CMD : NBL_OP_ADDR, ers[j]);
         end
         step(10);
         check("flash_busy", w[0], flash_busy);
         step(40);
      end
      check("chip_select_n", 1, chip_select_n);
      print_verdict();
   end
   initial begin
      #(20000 * 100);
      miscompares++;
      print_verdict();
   end
endmodule
`default_nettype wire
